// ===== fcs_pkg.sv
package fcs_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_TOTAL = 8'h08;
  localparam logic [7:0] ADDR_GROUP = 8'h0c;
  localparam logic [7:0] ADDR_PACE = 8'h10;
  localparam logic [7:0] ADDR_POST = 8'h14;
  localparam logic [7:0] ADDR_SPAN = 8'h18;
  localparam logic [7:0] ADDR_GOAL = 8'h1c;
  localparam logic [7:0] ADDR_WIN_ON = 8'h20;
  localparam logic [7:0] ADDR_WIN_XY = 8'h24;
  localparam logic [7:0] ADDR_WIN_WH = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2c;
  localparam logic [7:0] ADDR_LEVEL = 8'h30;
  localparam logic [7:0] ADDR_TL = 8'h34;
  // Command bits in the CMD word.
  localparam int CMD_BEGIN = 0;
  localparam int CMD_HALT = 1;
  localparam int CMD_FIRE = 2;
  // Timing: one microsecond in clock cycles.
  localparam int CLK_NS = 4;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_NS;
  // Reset values.
  localparam logic [15:0] TOTAL_RST = 16'h0001;
  localparam logic [15:0] GROUP_RST = 16'h0001;
  localparam logic [23:0] SPAN_RST = 24'h0003e8;
  localparam logic [7:0] GOAL_RST = 8'h80;
  typedef enum logic [1:0] {
    ONE_SHOT = 2'h0, COUNTED = 2'h1, FREE_RUN = 2'h2
  } fcs_kind_e;
  typedef enum logic [1:0] {
    ACT_RISE = 2'h0, ACT_FALL = 2'h1, ACT_HIGH = 2'h2, ACT_LOW = 2'h3
  } fcs_act_e;
  typedef enum logic [1:0] {
    POL_IDLE = 2'h0, POL_READOUT = 2'h1
  } fcs_pol_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_WAIT = 3'h1, ST_DELAY = 3'h3, ST_EXPOSE = 3'h2, ST_READ = 3'h6
  } fcs_state_e;
  // Control word layout, high bits first in the CTRL register.
  typedef struct packed {
    logic pace_permit;
    fcs_pol_e policy;
    fcs_act_e act;
    logic origin_hw;
    logic trig_on;
    fcs_kind_e kind;
  } fcs_ctrl_s;
  localparam fcs_ctrl_s CTRL_RST = '{1'b0, POL_IDLE, ACT_RISE, 1'b0, 1'b0, ONE_SHOT};
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] w;
    logic [15:0] h;
  } fcs_win_s;
endpackage

// ===== fcs_sequencer.sv
// The APB register port and the placing of the registers are this design's own decisions.
module fcs_sequencer (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic hw_trig_line,
  input logic readout_done,
  input logic [7:0] level_median,
  input logic [7:0] level_avg,
  input fcs_pkg::fcs_win_s user_region,
  output logic capture_busy,
  output logic expose_on,
  output logic frame_start,
  output logic [31:0] tl_param,
  output logic [23:0] span_us,
  output logic [7:0] auto_level_goal,
  output logic auto_window_on,
  output fcs_pkg::fcs_win_s auto_window_abs
);
  import fcs_pkg::*;

  fcs_ctrl_s ctrl_reg, ctrl_next;
  logic [15:0] total_reg, total_next, group_reg, group_next;
  logic [23:0] pace_reg, pace_next, post_reg, post_next, span_reg, span_next;
  logic [7:0] goal_reg, goal_next;
  logic win_on_reg, win_on_next;
  fcs_win_s win_reg, win_next, abs_reg, abs_next;
  logic [31:0] tl_reg, tl_next, prdata_reg, prdata_next;
  fcs_state_e state_reg, state_next;
  logic busy_reg, busy_next, halt_reg, halt_next, pend_reg, pend_next;
  logic start_reg, start_next, line_reg;
  logic [15:0] cnt_reg, cnt_next, burst_reg, burst_next;
  logic [7:0] div_reg, div_next;
  logic [23:0] us_reg, us_next, pace_cnt_reg, pace_cnt_next;
  logic setup, wr, mapped;
  logic cmd_begin, cmd_halt, cmd_fire, trig_evt, primed, us_tick;
  logic [15:0] len, left;

  // Setup and access share one address decode; the bus never waits.
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready && !pslverr;
  assign pready = 1'b1;
  always_comb begin
    if (paddr == ADDR_CTRL) mapped = 1'b1;
    else if (paddr == ADDR_CMD) mapped = 1'b1;
    else if (paddr == ADDR_TOTAL) mapped = 1'b1;
    else if (paddr == ADDR_GROUP) mapped = 1'b1;
    else if (paddr == ADDR_PACE) mapped = 1'b1;
    else if (paddr == ADDR_POST) mapped = 1'b1;
    else if (paddr == ADDR_SPAN) mapped = 1'b1;
    else if (paddr == ADDR_GOAL) mapped = 1'b1;
    else if (paddr == ADDR_WIN_ON) mapped = 1'b1;
    else if (paddr == ADDR_WIN_XY) mapped = 1'b1;
    else if (paddr == ADDR_WIN_WH) mapped = 1'b1;
    else if (paddr == ADDR_STATUS) mapped = 1'b1;
    else if (paddr == ADDR_LEVEL) mapped = 1'b1;
    else if (paddr == ADDR_TL) mapped = 1'b1;
    else mapped = 1'b0;
  end

  // Unmapped words and transport writes during a capture raise an error.
  assign pslverr = psel && penable && (!mapped || (pwrite && paddr == ADDR_TL && busy_reg));
  assign prdata = prdata_reg;

  // Commands are write-only pulses decoded from the CMD word.
  assign cmd_begin = wr && paddr == ADDR_CMD && pwdata[CMD_BEGIN];
  assign cmd_halt = wr && paddr == ADDR_CMD && pwdata[CMD_HALT];
  assign cmd_fire = wr && paddr == ADDR_CMD && pwdata[CMD_FIRE] && !ctrl_reg.origin_hw;

  // Trigger qualification by origin and active state.
  always_comb begin
    trig_evt = cmd_fire;
    if (ctrl_reg.origin_hw) begin
      case (ctrl_reg.act)
        ACT_RISE: trig_evt = hw_trig_line && !line_reg;
        ACT_FALL: trig_evt = !hw_trig_line && line_reg;
        ACT_HIGH: trig_evt = hw_trig_line;
        default: trig_evt = !hw_trig_line;
      endcase
    end
  end

  // Primed only where the accept policy lets a trigger in; others are dropped.
  assign primed = busy_reg && ctrl_reg.trig_on && burst_reg == 16'h0000 &&
    (state_reg == ST_WAIT ||
     (ctrl_reg.policy == POL_READOUT && state_reg == ST_READ && !pend_reg));

  // Burst length: one in one-shot, never past the total in counted mode.
  assign left = total_reg - cnt_reg;
  always_comb begin
    len = (group_reg == 16'h0000) ? 16'h0001 : group_reg;
    if (ctrl_reg.kind == ONE_SHOT) len = 16'h0001;
    else if (ctrl_reg.kind == COUNTED && len > left) len = left;
  end

  assign us_tick = div_reg == 8'(US_CYC - 1);

  // Register file next values.
  always_comb begin
    ctrl_next = ctrl_reg;
    total_next = total_reg;
    group_next = group_reg;
    pace_next = pace_reg;
    post_next = post_reg;
    span_next = span_reg;
    goal_next = goal_reg;
    win_on_next = win_on_reg;
    win_next = win_reg;
    tl_next = tl_reg;
    if (wr) begin
      if (paddr == ADDR_CTRL) ctrl_next = fcs_ctrl_s'(pwdata[8:0]);
      else if (paddr == ADDR_TOTAL) total_next = pwdata[15:0];
      else if (paddr == ADDR_GROUP) group_next = pwdata[15:0];
      else if (paddr == ADDR_PACE && ctrl_reg.pace_permit) pace_next = pwdata[23:0];
      else if (paddr == ADDR_POST) post_next = pwdata[23:0];
      else if (paddr == ADDR_SPAN) span_next = pwdata[23:0];
      else if (paddr == ADDR_GOAL) goal_next = pwdata[7:0];
      else if (paddr == ADDR_WIN_ON) win_on_next = pwdata[0];
      else if (paddr == ADDR_WIN_XY) begin
        win_next.x = pwdata[15:0];
        win_next.y = pwdata[31:16];
      end else if (paddr == ADDR_WIN_WH) begin
        win_next.w = pwdata[15:0];
        win_next.h = pwdata[31:16];
      end else if (paddr == ADDR_TL) tl_next = pwdata;
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle.
  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      if (paddr == ADDR_CTRL) prdata_next = {23'h0, ctrl_reg};
      else if (paddr == ADDR_TOTAL) prdata_next = {16'h0, total_reg};
      else if (paddr == ADDR_GROUP) prdata_next = {16'h0, group_reg};
      else if (paddr == ADDR_PACE) prdata_next = {8'h0, pace_reg};
      else if (paddr == ADDR_POST) prdata_next = {8'h0, post_reg};
      else if (paddr == ADDR_SPAN) prdata_next = {8'h0, span_reg};
      else if (paddr == ADDR_GOAL) prdata_next = {24'h0, goal_reg};
      else if (paddr == ADDR_WIN_ON) prdata_next = {31'h0, win_on_reg};
      else if (paddr == ADDR_WIN_XY) prdata_next = {win_reg.y, win_reg.x};
      else if (paddr == ADDR_WIN_WH) prdata_next = {win_reg.h, win_reg.w};
      else if (paddr == ADDR_STATUS)
        prdata_next = {cnt_reg, 9'h0, state_reg, pend_reg, halt_reg, primed, busy_reg};
      else if (paddr == ADDR_LEVEL) prdata_next = {16'h0, level_avg, level_median};
      else if (paddr == ADDR_TL) prdata_next = tl_reg;
      else prdata_next = 32'h0000_0000;
    end
  end

  // Effective window in absolute coordinates (user-region origin plus offset), or the whole region when off.
  always_comb begin
    abs_next = user_region;
    if (win_on_reg) begin
      abs_next.x = user_region.x + win_reg.x;
      abs_next.y = user_region.y + win_reg.y;
      abs_next.w = win_reg.w;
      abs_next.h = win_reg.h;
    end
  end

  // Capture sequencer next values.
  always_comb begin
    state_next = state_reg;
    busy_next = busy_reg;
    halt_next = halt_reg;
    pend_next = pend_reg;
    cnt_next = cnt_reg;
    burst_next = burst_reg;
    start_next = 1'b0;
    div_next = us_tick ? 8'h00 : div_reg + 8'h01;
    us_next = (us_tick && us_reg != 24'hffffff) ? us_reg + 24'h000001 : us_reg;
    pace_cnt_next = (us_tick && pace_cnt_reg != 24'hffffff) ? pace_cnt_reg + 24'h000001 :
      pace_cnt_reg;
    if (trig_evt && primed && state_reg == ST_READ) pend_next = 1'b1;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_begin && !(ctrl_reg.kind == COUNTED && total_reg == 16'h0000)) begin
          busy_next = 1'b1;
          cnt_next = 16'h0000;
          burst_next = 16'h0000;
          halt_next = 1'b0;
          pend_next = 1'b0;
          pace_cnt_next = 24'hffffff;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cmd_halt) begin
          busy_next = 1'b0;
          state_next = ST_IDLE;
        end else if (ctrl_reg.trig_on) begin
          if (burst_reg != 16'h0000 || pend_reg || (trig_evt && primed)) begin
            if (burst_reg == 16'h0000) burst_next = len;
            pend_next = 1'b0;
            div_next = 8'h00;
            us_next = 24'h000000;
            state_next = (burst_reg != 16'h0000) ? ST_EXPOSE : ST_DELAY;
            start_next = burst_reg != 16'h0000;
          end
        end else if (!ctrl_reg.pace_permit || pace_cnt_reg >= pace_reg) begin
          div_next = 8'h00;
          us_next = 24'h000000;
          pace_cnt_next = 24'h000000;
          start_next = 1'b1;
          state_next = ST_EXPOSE;
        end
      end
      ST_DELAY: begin
        if (cmd_halt) begin
          busy_next = 1'b0;
          state_next = ST_IDLE;
        end else if (us_reg >= post_reg) begin
          div_next = 8'h00;
          us_next = 24'h000000;
          start_next = 1'b1;
          state_next = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (cmd_halt) halt_next = 1'b1;
        if (us_reg >= span_reg) state_next = ST_READ;
      end
      default: begin
        if (cmd_halt) halt_next = 1'b1;
        if (readout_done) begin
          cnt_next = cnt_reg + 16'h0001;
          if (burst_reg != 16'h0000) burst_next = burst_reg - 16'h0001;
          state_next = ST_WAIT;
          if (halt_reg || cmd_halt || ctrl_reg.kind == ONE_SHOT ||
              (ctrl_reg.kind == COUNTED && cnt_next >= total_reg)) begin
            busy_next = 1'b0;
            burst_next = 16'h0000;
            pend_next = 1'b0;
            state_next = ST_IDLE;
          end
        end
      end
    endcase
  end

  // Every frame of a burst, the first included, counts in the decrement on readout.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      total_reg <= TOTAL_RST;
      group_reg <= GROUP_RST;
      pace_reg <= 24'h000000;
      post_reg <= 24'h000000;
      span_reg <= SPAN_RST;
      goal_reg <= GOAL_RST;
      win_on_reg <= 1'b0;
      win_reg <= '0;
      abs_reg <= '0;
      tl_reg <= 32'h0000_0000;
      prdata_reg <= 32'h0000_0000;
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      halt_reg <= 1'b0;
      pend_reg <= 1'b0;
      start_reg <= 1'b0;
      line_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      burst_reg <= 16'h0000;
      div_reg <= 8'h00;
      us_reg <= 24'h000000;
      pace_cnt_reg <= 24'h000000;
    end else begin
      ctrl_reg <= ctrl_next;
      total_reg <= total_next;
      group_reg <= group_next;
      pace_reg <= pace_next;
      post_reg <= post_next;
      span_reg <= span_next;
      goal_reg <= goal_next;
      win_on_reg <= win_on_next;
      win_reg <= win_next;
      abs_reg <= abs_next;
      tl_reg <= tl_next;
      prdata_reg <= prdata_next;
      state_reg <= state_next;
      busy_reg <= busy_next;
      halt_reg <= halt_next;
      pend_reg <= pend_next;
      start_reg <= start_next;
      line_reg <= hw_trig_line;
      cnt_reg <= cnt_next;
      burst_reg <= burst_next;
      div_reg <= div_next;
      us_reg <= us_next;
      pace_cnt_reg <= pace_cnt_next;
    end
  end

  // Outputs straight from registers, expose_on decoded from the state register.
  assign capture_busy = busy_reg;
  assign expose_on = state_reg == ST_EXPOSE;
  assign frame_start = start_reg;
  assign tl_param = tl_reg;
  assign span_us = span_reg;
  assign auto_level_goal = goal_reg;
  assign auto_window_on = win_on_reg;
  assign auto_window_abs = abs_reg;

  // A one-shot capture never counts beyond one frame.
  chk_one_shot_count: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg.kind == ONE_SHOT && $fell(busy_reg)) |-> cnt_reg <= 16'h0001)
    else $error("one-shot capture counted more than one frame");

  // A counted capture stops exactly at the total unless halted early.
  chk_counted_end: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_READ && readout_done && ctrl_reg.kind == COUNTED && !halt_reg &&
     !cmd_halt && cnt_reg + 16'h0001 == total_reg) |=> (!busy_reg && state_reg == ST_IDLE))
    else $error("counted capture did not end at its total");

  // The count never passes the total in counted mode.
  chk_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg.kind == COUNTED && busy_reg && $stable(ctrl_reg)) |-> cnt_reg <= total_reg)
    else $error("counted capture exceeded its total");

  // Free-running capture keeps going after a frame without a halt.
  chk_free_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg.kind == FREE_RUN && state_reg == ST_READ && readout_done && !halt_reg &&
     !cmd_halt) |=> (busy_reg && state_reg == ST_WAIT))
    else $error("free-running capture stopped without a halt");

  // A halt inside a frame leaves the exposure running to readout.
  chk_halt_finish: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_EXPOSE && cmd_halt && us_reg < span_reg) |=> (state_reg == ST_EXPOSE &&
     halt_reg && busy_reg))
    else $error("frame was cut short by a halt");

  // Transport parameter holds still during a capture.
  chk_tl_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (busy_reg && $past(busy_reg)) |-> $stable(tl_reg))
    else $error("transport parameter changed during a capture");

  // The first frame of a triggered group starts only after the postpone interval.
  chk_postpone: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_DELAY ##1 state_reg == ST_EXPOSE) |-> $past(us_reg) >= $past(post_reg))
    else $error("trigger acted on before its postpone interval");

  // Without a trigger event the wait state never leads to the delay state.
  chk_unprimed_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WAIT && ctrl_reg.trig_on && burst_reg == 16'h0000 && !pend_reg &&
     !trig_evt) |=> state_reg != ST_DELAY)
    else $error("frame began without an accepted trigger");

  // A fire command on the hardware origin is no trigger.
  chk_fire_origin: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg.origin_hw && ctrl_reg.act == ACT_RISE && !(hw_trig_line && !line_reg) &&
     state_reg == ST_WAIT && burst_reg == 16'h0000 && !pend_reg) |=> state_reg != ST_DELAY)
    else $error("software fire acted with hardware origin");

  // Pacing holds frames apart by the pace value while triggering is off.
  chk_pace_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_reg.trig_on && ctrl_reg.pace_permit && state_reg == ST_WAIT &&
     pace_cnt_reg < pace_reg) |=> !start_reg)
    else $error("paced frame started early");

  // Begin clears the captured-frame count.
  chk_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy_reg) |-> cnt_reg == 16'h0000)
    else $error("frame count not cleared on begin");

  // One-shot loads a group of one frame, whatever the group length register says.
  chk_one_shot_group: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg.kind == ONE_SHOT && state_reg == ST_WAIT && $stable(ctrl_reg)) |=>
    burst_reg <= 16'h0001)
    else $error("one-shot capture loaded a group longer than one frame");
endmodule

// ===== fcs_readout_model.sv
// Readout side of the sensor: answers each exposure with a one-cycle done pulse after a lag.
module fcs_readout_model #(
  parameter int LAG = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic expose_on,
  output logic readout_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic exp_d;
  // A lag longer than one cycle makes the sequencer really wait in its readout state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      exp_d <= 1'b0;
      readout_done <= 1'b0;
    end else begin
      exp_d <= expose_on;
      readout_done <= 1'b0;
      if (exp_d && !expose_on) begin
        cnt <= LAG;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        readout_done <= (cnt == 1);
      end
    end
  end
endmodule

// ===== tb_frame_capture_sequencer.sv
module tb_frame_capture_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import fcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, hw_trig_line, readout_done;
  logic [7:0] paddr, level_median, level_avg, auto_level_goal;
  logic [31:0] pwdata, prdata, tl_param, r;
  logic pready, pslverr, capture_busy, expose_on, frame_start, auto_window_on;
  logic [23:0] span_us;
  fcs_win_s user_region, auto_window_abs;
  logic [64:0] q[$];
  logic [64:0] e;
  int seed = 33;
  int miscompares = 0;
  int compares = 0;
  int fs = 0;
  int cyc = 0;
  int f0, c0;
  fcs_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_trig_line(hw_trig_line), .readout_done(readout_done),
    .level_median(level_median), .level_avg(level_avg), .user_region(user_region),
    .capture_busy(capture_busy), .expose_on(expose_on), .frame_start(frame_start),
    .tl_param(tl_param), .span_us(span_us), .auto_level_goal(auto_level_goal),
    .auto_window_on(auto_window_on), .auto_window_abs(auto_window_abs));
  fcs_readout_model #(.LAG(5)) sensor (.pclk(pclk), .presetn(presetn), .expose_on(expose_on),
    .readout_done(readout_done));
  always #2 pclk = ~pclk;
  // Frame and cycle counters give the scenarios a time base independent of bus traffic.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (frame_start === 1'b1) fs <= fs + 1;
  end
  // Each completed access takes the oldest note: expected error flag, data mask, data.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      compares++;
      if (pslverr !== e[64] || (prdata & e[63:32]) !== e[31:0]) begin
        miscompares++;
        $display("Error %0t: access %h got %h err %b", $time, paddr, prdata, pslverr);
      end
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [64:0] x);
    q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    apb(1'b1, a, d, {err, 64'h0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1);
    apb(1'b0, a, 32'h0, {1'b0, m, d});
  endtask
  task automatic stat(input logic [15:0] n, input logic b);
    rd(ADDR_STATUS, {n, 15'h0, b}, 32'hffff0001);
  endtask
  task automatic chk(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error %0t: port check failed", $time);
    end
  endtask
  task automatic waitb(input logic v);
    for (int n = 0; n < 4000 && capture_busy !== v; n++) @(posedge pclk);
    chk(capture_busy === v);
  endtask
  task automatic waitfs(input int n);
    for (int k = 0; k < 4000 && fs < n; k++) @(posedge pclk);
    chk(fs >= n);
  endtask
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog sized well above the longest capture sequence below.
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, hw_trig_line, paddr, pwdata} = '0;
    level_median = 8'($random(seed));
    level_avg = 8'($random(seed));
    user_region = {$random(seed), $random(seed)};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_TOTAL, 32'h1);
    rd(ADDR_GROUP, 32'h1);
    rd(ADDR_SPAN, 32'h3e8);
    rd(ADDR_CTRL, 32'h0);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 64'h0});
    r = $random(seed);
    wr(ADDR_GOAL, r);
    rd(ADDR_GOAL, {24'h0, r[7:0]});
    chk(auto_level_goal === r[7:0]);
    rd(ADDR_LEVEL, {level_avg, level_median}, 32'hffff);
    wr(ADDR_WIN_ON, 32'h1);
    rd(ADDR_WIN_ON, 32'h1);
    chk(auto_window_on === 1'b1);
    wr(ADDR_WIN_XY, {16'h3, 16'h5});
    wr(ADDR_WIN_WH, {16'h7, 16'h9});
    repeat (2) @(posedge pclk);
    chk(auto_window_abs.x === user_region.x + 16'h5);
    chk(auto_window_abs.y === user_region.y + 16'h3);
    chk(auto_window_abs.w === 16'h9 && auto_window_abs.h === 16'h7);
    $display("Test registers done");
    // Short spans keep every frame near 250 cycles.
    wr(ADDR_SPAN, 32'h1);
    chk(span_us === 24'h000001);
    wr(ADDR_POST, 32'h2);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_TL, 32'h1234, 1'b1);
    waitb(1'b0);
    stat(16'h1, 1'b0);
    rd(ADDR_TL, 32'h0);
    chk(tl_param === 32'h0000_0000);
    $display("Test one-shot done");
    wr(ADDR_TOTAL, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    repeat (2) begin
      wr(ADDR_CMD, 32'h1);
      waitb(1'b0);
      stat(16'h3, 1'b0);
    end
    $display("Test counted done");
    wr(ADDR_CTRL, 32'h2);
    f0 = fs;
    wr(ADDR_CMD, 32'h1);
    waitfs(f0 + 2);
    chk(expose_on === 1'b1 && capture_busy === 1'b1);
    wr(ADDR_CMD, 32'h2);
    waitb(1'b0);
    stat(16'h2, 1'b0);
    $display("Test free-run done");
    // A fire while idle is dropped, not latched for the next capture.
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_CMD, 32'h4);
    wr(ADDR_CMD, 32'h1);
    repeat (700) @(posedge pclk);
    stat(16'h0, 1'b1);
    wr(ADDR_CMD, 32'h2);
    waitb(1'b0);
    stat(16'h0, 1'b0);
    wr(ADDR_CTRL, 32'hc);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h4);
    repeat (700) @(posedge pclk);
    stat(16'h0, 1'b1);
    f0 = fs;
    hw_trig_line <= 1'b1;
    c0 = cyc;
    waitfs(f0 + 1);
    chk(cyc - c0 >= 500 && cyc - c0 <= 520);
    hw_trig_line <= 1'b0;
    waitb(1'b0);
    stat(16'h1, 1'b0);
    wr(ADDR_GROUP, 32'h2);
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h4);
    waitb(1'b0);
    stat(16'h1, 1'b0);
    $display("Test triggers done");
    // A group of two, then a second trigger whose group is cut to the one frame left.
    wr(ADDR_CTRL, 32'h5);
    f0 = fs;
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h4);
    waitfs(f0 + 2);
    repeat (300) @(posedge pclk);
    stat(16'h2, 1'b1);
    wr(ADDR_CMD, 32'h4);
    waitb(1'b0);
    stat(16'h3, 1'b0);
    $display("Test burst done");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_PACE, 32'h5);
    rd(ADDR_PACE, 32'h0);
    wr(ADDR_CTRL, 32'h100);
    wr(ADDR_PACE, 32'h5);
    rd(ADDR_PACE, 32'h5);
    // Free-running with pacing on: frame starts sit five microseconds apart.
    wr(ADDR_CTRL, 32'h102);
    f0 = fs;
    wr(ADDR_CMD, 32'h1);
    waitfs(f0 + 1);
    c0 = cyc;
    waitfs(f0 + 2);
    chk(cyc - c0 >= 1250 && cyc - c0 <= 1260);
    wr(ADDR_CMD, 32'h2);
    waitb(1'b0);
    stat(16'h2, 1'b0);
    $display("Test pace done");
    print_verdict();
  end
endmodule
